/* File: hw/sfc_freq_ctrl.sv */
module sfc_freq_ctrl
  import sfc_pkg::*;
#(
  parameter int TUNE_CNT = sfc_pkg::TUNE_CYCLES
)(
  input  wire logic                         REF_CLK,
  input  wire logic                         ARST_N,
  input  wire logic                         CE,
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  input  wire logic [6:0]                   REG_ADDR,
  input  wire logic [7:0]                   REG_WDATA,
  output logic      [7:0]                   REG_RDATA,
  input  wire logic                         MODE_TX,
  input  wire logic                         MODE_RX,
  input  wire logic                         PKT_BUSY,
  input  wire logic                         TX_DATA,
  input  wire logic                         AFC_EN,
  input  wire logic signed [9:0]            AFC_CORR,
  output logic signed [sfc_pkg::WORD_W-1:0] SYNTH_WORD,
  output logic                              HALF_BAND,
  output logic                              SETTLING,
  output logic                              TX_ACTIVE,
  output logic                              RX_ACTIVE
);
  import sfc_pkg::*;

  logic [7:0]               mod2_reg;
  logic [7:0]               dev_reg;
  logic [7:0]               ofs_lo_reg;
  logic [1:0]               ofs_hi_reg;
  logic [7:0]               band_reg;
  logic [7:0]               fc_hi_reg;
  logic [7:0]               fc_lo_reg;
  logic [7:0]               hop_ch_reg;
  logic [7:0]               hop_step_reg;
  sfc_state_t               state_reg;
  sfc_state_t               state_next;
  logic                     ret_tx_reg;
  logic                     pend_reg;
  logic [31:0]              cnt_reg;
  logic signed [WORD_W-1:0] base_reg;
  logic signed [WORD_W-1:0] base_calc;
  logic signed [WORD_W-1:0] dev_term;
  logic signed [WORD_W-1:0] word_next;
  logic signed [9:0]        ofs_sel;
  logic [8:0]               dev_code;
  logic                     hop_wr;
  logic                     fifo_tx;
  logic                     hold_pkt;
  logic                     tune_done;
  logic                     load;
  logic                     afc_on_reg;

  function automatic logic [4:0] clamp_fb(input logic [4:0] v);
    clamp_fb = (v > FB_MAX) ? FB_MAX : v;
  endfunction

  assign hop_wr    = REG_WR && (REG_ADDR == ADDR_HOP_CH || REG_ADDR == ADDR_HOP_STEP);
  assign fifo_tx   = mod2_reg[DTMOD_LSB +: 2] == DTMOD_FIFO;
  assign hold_pkt  = fifo_tx && PKT_BUSY;
  assign tune_done = cnt_reg >= 32'(TUNE_CNT - 1);
  assign dev_code  = {mod2_reg[FD8_BIT], dev_reg};

  // register writes
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mod2_reg     <= RST_MOD2;
      dev_reg      <= RST_DEV;
      ofs_lo_reg   <= RST_OFS_LO;
      ofs_hi_reg   <= RST_OFS_HI;
      band_reg     <= RST_BAND;
      fc_hi_reg    <= RST_FC_HI;
      fc_lo_reg    <= RST_FC_LO;
      hop_ch_reg   <= RST_HOP_CH;
      hop_step_reg <= RST_HOP_STEP;
    end else if (CE && REG_WR) begin
      if (REG_ADDR == ADDR_MOD2) begin
        mod2_reg <= REG_WDATA;
      end else if (REG_ADDR == ADDR_DEV) begin
        dev_reg <= REG_WDATA;
      end else if (REG_ADDR == ADDR_OFS_LO) begin
        ofs_lo_reg <= REG_WDATA;
      end else if (REG_ADDR == ADDR_OFS_HI) begin
        ofs_hi_reg <= REG_WDATA[1:0];
      end else if (REG_ADDR == ADDR_BAND) begin
        band_reg <= {REG_WDATA[7:5] & BAND_WR_MASK[7:5], clamp_fb(REG_WDATA[4:0])};
      end else if (REG_ADDR == ADDR_FC_HI) begin
        fc_hi_reg <= REG_WDATA;
      end else if (REG_ADDR == ADDR_FC_LO) begin
        fc_lo_reg <= REG_WDATA;
      end else if (REG_ADDR == ADDR_HOP_CH) begin
        hop_ch_reg <= REG_WDATA;
      end else if (REG_ADDR == ADDR_HOP_STEP) begin
        hop_step_reg <= REG_WDATA;
      end
    end
  end

  // register reads
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else if (CE && REG_RD) begin
      if (REG_ADDR == ADDR_MOD2) begin
        REG_RDATA <= mod2_reg;
      end else if (REG_ADDR == ADDR_DEV) begin
        REG_RDATA <= dev_reg;
      end else if (REG_ADDR == ADDR_OFS_LO) begin
        REG_RDATA <= ofs_lo_reg;
      end else if (REG_ADDR == ADDR_OFS_HI) begin
        REG_RDATA <= {6'h00, ofs_hi_reg};
      end else if (REG_ADDR == ADDR_BAND) begin
        REG_RDATA <= band_reg;
      end else if (REG_ADDR == ADDR_FC_HI) begin
        REG_RDATA <= fc_hi_reg;
      end else if (REG_ADDR == ADDR_FC_LO) begin
        REG_RDATA <= fc_lo_reg;
      end else if (REG_ADDR == ADDR_HOP_CH) begin
        REG_RDATA <= hop_ch_reg;
      end else if (REG_ADDR == ADDR_HOP_STEP) begin
        REG_RDATA <= hop_step_reg;
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end

  // one shared offset path into the calculator: manual code or automatic correction
  always_comb begin
    if (AFC_EN && state_reg == ST_RX) begin
      ofs_sel = AFC_CORR;
    end else begin
      ofs_sel = signed'({ofs_hi_reg, ofs_lo_reg});
    end
  end

  sfc_ratio_calc u_calc (
    .clk       (REF_CLK),
    .arst_n    (ARST_N),
    .fb        (band_reg[4:0]),
    .fc        ({fc_hi_reg, fc_lo_reg}),
    .hbsel     (band_reg[HBSEL_BIT]),
    .hop_step  (hop_step_reg),
    .hop_chan  (hop_ch_reg),
    .ofs       (ofs_sel),
    .base_word (base_calc),
    .hop_term  ()
  );

  // mode sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (MODE_TX || MODE_RX) begin
          state_next = ST_TUNE;
        end
      end
      ST_TX: begin
        if (!MODE_TX) begin
          state_next = ST_IDLE;
        end else if ((hop_wr || pend_reg) && !hold_pkt) begin
          state_next = ST_TUNE;
        end
      end
      ST_RX: begin
        if (!MODE_RX) begin
          state_next = ST_IDLE;
        end else if (hop_wr) begin
          state_next = ST_TUNE;
        end
      end
      ST_TUNE: begin
        if (tune_done) begin
          state_next = ret_tx_reg ? ST_TX : ST_RX;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= ST_IDLE;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // return target for the settle pass
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ret_tx_reg <= 1'b0;
    end else if (CE && state_reg == ST_IDLE) begin
      ret_tx_reg <= MODE_TX;
    end
  end

  // deferred hop while a FIFO packet is in flight
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_reg <= 1'b0;
    end else if (CE) begin
      if (state_reg == ST_TX && hop_wr && hold_pkt) begin
        pend_reg <= 1'b1;
      end else if (state_reg != ST_TX) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // settle counter
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_reg <= 32'h0000_0000;
    end else if (CE) begin
      cnt_reg <= (state_reg == ST_TUNE) ? cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // correction was on last cycle: one more reload brings the manual code back
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      afc_on_reg <= 1'b0;
    end else if (CE) begin
      afc_on_reg <= AFC_EN;
    end
  end

  // atomic base word: tracks while idle and in receive with correction on, loaded once per retune
  assign load = (state_reg == ST_IDLE) || (state_reg == ST_TUNE && cnt_reg == 32'h0000_0000)
              || (state_reg == ST_RX && (AFC_EN || afc_on_reg));
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      base_reg <= '0;
    end else if (CE && load) begin
      base_reg <= base_calc;
    end
  end

  // symmetric deviation, fixed 625 Hz steps regardless of band
  always_comb begin
    dev_term = signed'((WORD_W'(dev_code) * WORD_W'(DEV_SCALE)) >> band_reg[HBSEL_BIT]);
    if (state_reg == ST_TX && mod2_reg[MODTYP_LSB + 1]) begin
      word_next = TX_DATA ? base_reg + dev_term : base_reg - dev_term;
    end else begin
      word_next = base_reg;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SYNTH_WORD <= '0;
    end else if (CE) begin
      SYNTH_WORD <= word_next;
    end
  end

  assign HALF_BAND = band_reg[HBSEL_BIT];
  assign SETTLING  = state_reg == ST_TUNE;
  assign TX_ACTIVE = state_reg == ST_TX;
  assign RX_ACTIVE = state_reg == ST_RX;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  a_hop_retune: assert property (CE && state_reg == ST_RX && MODE_RX && hop_wr
    |=> state_reg == ST_TUNE)
    else $error("hop write in receive did not start settle");
  a_tune_return: assert property (CE && state_reg == ST_TUNE && tune_done
    |=> state_reg == ($past(ret_tx_reg) ? ST_TX : ST_RX))
    else $error("settle did not return to previous mode");
  a_pkt_hold: assert property (CE && state_reg == ST_TX && MODE_TX && hold_pkt
    |=> state_reg == ST_TX && $stable(base_reg))
    else $error("frequency changed during fifo packet");
  a_pend_apply: assert property (CE && state_reg == ST_TX && MODE_TX
    && pend_reg && !hold_pkt |=> state_reg == ST_TUNE)
    else $error("deferred hop not applied after packet");
  a_fb_clamp: assert property (band_reg[4:0] <= FB_MAX)
    else $error("band code above limit");
  a_base_atomic: assert property (!$stable(base_reg) |-> $past(load && CE))
    else $error("base word changed outside a retune");
  a_ofs_share: assert property (state_reg == ST_RX && AFC_EN |-> ofs_sel == AFC_CORR)
    else $error("manual offset used while correction active");
  a_dev_symm: assert property (CE && state_reg == ST_TX && mod2_reg[MODTYP_LSB + 1]
    |=> (SYNTH_WORD - $past(base_reg)) == ($past(TX_DATA) ? $past(dev_term)
    : -$past(dev_term)))
    else $error("deviation not symmetric about centre");
  a_no_dev_rx: assert property (CE && state_reg != ST_TX |=> SYNTH_WORD == $past(base_reg))
    else $error("deviation applied outside transmit");

  c_hop_rx: cover property (state_reg == ST_RX && hop_wr ##1 state_reg == ST_TUNE);
  c_deferred: cover property (pend_reg && !hold_pkt ##1 state_reg == ST_TUNE);
  c_fsk_tx: cover property (state_reg == ST_TX && mod2_reg[MODTYP_LSB + 1] && TX_DATA);
endmodule

/* File: hw/sfc_pkg.sv */
package sfc_pkg;
  localparam logic [6:0]  ADDR_MOD2      = 7'h71;
  localparam logic [6:0]  ADDR_DEV       = 7'h72;
  localparam logic [6:0]  ADDR_OFS_LO    = 7'h73;
  localparam logic [6:0]  ADDR_OFS_HI    = 7'h74;
  localparam logic [6:0]  ADDR_BAND      = 7'h75;
  localparam logic [6:0]  ADDR_FC_HI     = 7'h76;
  localparam logic [6:0]  ADDR_FC_LO     = 7'h77;
  localparam logic [6:0]  ADDR_HOP_CH    = 7'h79;
  localparam logic [6:0]  ADDR_HOP_STEP  = 7'h7A;

  localparam logic [7:0]  RST_MOD2       = 8'h00;
  localparam logic [7:0]  RST_DEV        = 8'h20;
  localparam logic [7:0]  RST_OFS_LO     = 8'h00;
  localparam logic [1:0]  RST_OFS_HI     = 2'h0;
  localparam logic [7:0]  RST_BAND       = 8'h35;
  localparam logic [7:0]  RST_FC_HI      = 8'hBB;
  localparam logic [7:0]  RST_FC_LO      = 8'h80;
  localparam logic [7:0]  RST_HOP_CH     = 8'h00;
  localparam logic [7:0]  RST_HOP_STEP   = 8'h00;

  localparam int          FD8_BIT        = 2;
  localparam int          MODTYP_LSB     = 0;
  localparam int          DTMOD_LSB      = 4;
  localparam int          HBSEL_BIT      = 5;
  localparam int          SBSEL_BIT      = 6;
  localparam logic [1:0]  DTMOD_FIFO     = 2'h2;
  localparam logic [7:0]  BAND_WR_MASK   = 8'h7F;

  localparam logic [4:0]  FB_MAX         = 5'h17;
  localparam int          N_FIXED        = 24;
  localparam int          FRAC_MOD       = 64000;
  localparam int          REF_HZ         = 10000000;
  localparam int          HOP_STEP_HZ    = 10000;
  localparam int          DEV_STEP_HZ    = 625;
  localparam int          HOP_SCALE      = HOP_STEP_HZ * FRAC_MOD / REF_HZ;
  localparam int          DEV_SCALE      = DEV_STEP_HZ * FRAC_MOD / REF_HZ;

  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          TUNE_TIME_NS   = 200000;
  localparam int          TUNE_CYCLES    = (TUNE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int          WORD_W         = 32;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TX   = 4'b0010,
    ST_RX   = 4'b0100,
    ST_TUNE = 4'b1000
  } sfc_state_t;
endpackage

/* File: hw/sfc_ratio_calc.sv */
module sfc_ratio_calc
  import sfc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic [4:0]               fb,
  input  wire logic [15:0]              fc,
  input  wire logic                     hbsel,
  input  wire logic [7:0]               hop_step,
  input  wire logic [7:0]               hop_chan,
  input  wire logic signed [9:0]        ofs,
  output logic signed [sfc_pkg::WORD_W-1:0] base_word,
  output logic signed [sfc_pkg::WORD_W-1:0] hop_term
);
  logic [WORD_W-1:0] hop_raw;
  logic [WORD_W-1:0] int_part;

  always_comb begin
    hop_raw   = WORD_W'(hop_step) * WORD_W'(hop_chan) * WORD_W'(HOP_SCALE);
    hop_term  = signed'(hop_raw >> hbsel);
    int_part  = (WORD_W'(fb) + WORD_W'(N_FIXED)) * WORD_W'(FRAC_MOD);
    base_word = signed'(int_part) + signed'(WORD_W'(fc)) + hop_term
              + WORD_W'(ofs);
  end

  a_hop_scale: assert property (@(posedge clk) disable iff (!arst_n)
    hop_term * (1 + hbsel) == hop_step * hop_chan * HOP_SCALE)
    else $error("hop term does not match step times channel");
endmodule

/* File: sim/sfc_freq_ctrl_tb_top.sv */
module sfc_freq_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic              REF_CLK = 1'b0;
  logic              ARST_N = 1'b0;
  logic              CE, REG_WR, REG_RD;
  logic [6:0]        REG_ADDR;
  logic [7:0]        REG_WDATA, REG_RDATA;
  logic              MODE_TX = 1'b0, MODE_RX = 1'b0, PKT_BUSY = 1'b0, TX_DATA = 1'b0;
  logic              AFC_EN = 1'b0;
  logic signed [9:0] AFC_CORR = 10'sh000;
  logic signed [31:0] SYNTH_WORD;
  logic              HALF_BAND, SETTLING, TX_ACTIVE, RX_ACTIVE;
  int                err_count = 0;
  int                tests_run = 0;
  int fb = 21, fc = 48000, hb = 1, hs = 0, hc = 0, of = 0, dev = 0;
  logic [6:0] ra [10] = '{7'h71, 7'h72, 7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h78, 7'h79, 7'h7A};
  logic [7:0] rv [10] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h35, 8'hBB, 8'h80, 8'h00, 8'h00, 8'h00};

  always #10 REF_CLK = ~REF_CLK;

  sfc_host_model host (.clk(REF_CLK), .ce(CE), .reg_wr(REG_WR), .reg_rd(REG_RD),
    .reg_addr(REG_ADDR), .reg_wdata(REG_WDATA), .reg_rdata(REG_RDATA));

  sfc_freq_ctrl #(.TUNE_CNT(8)) DUT (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CE(CE),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .MODE_TX(MODE_TX), .MODE_RX(MODE_RX), .PKT_BUSY(PKT_BUSY),
    .TX_DATA(TX_DATA), .AFC_EN(AFC_EN), .AFC_CORR(AFC_CORR), .SYNTH_WORD(SYNTH_WORD),
    .HALF_BAND(HALF_BAND), .SETTLING(SETTLING), .TX_ACTIVE(TX_ACTIVE),
    .RX_ACTIVE(RX_ACTIVE));

  function automatic logic [31:0] exp_word(input int sgn);
    int w;
    w = (fb + 24) * 64000 + fc + hs * hc * (hb ? 32 : 64) + of + sgn * dev * (hb ? 2 : 4);
    return 32'(w);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk({24'h0, d}, {24'h0, e});
  endtask

  // wait three clocks then compare the synthesizer word
  task automatic wchk(input int sgn);
    repeat (3) @(posedge REF_CLK);
    #1;
    chk(SYNTH_WORD, exp_word(sgn));
  endtask

  // bounded wait for settle, transmit or receive state
  task automatic wait_for(input int which);
    logic f;
    f = 1'b0;
    for (int i = 0; i < 100 && f !== 1'b1; i++) begin
      @(posedge REF_CLK);
      #1;
      f = (which == 0) ? SETTLING : (which == 1) ? TX_ACTIVE : RX_ACTIVE;
    end
    chk({31'h0, f}, 32'h1);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    for (int i = 0; i < 10; i++) rchk(ra[i], rv[i]);
    host.wr(7'h74, 8'hFF);
    rchk(7'h74, 8'h03);
    host.wr(7'h75, 8'hFF);
    rchk(7'h75, 8'h77);
    host.wr(7'h74, 8'h00);
    host.wr(7'h75, 8'h35);
    $display("test registers done");
    wchk(0);
    hs = 100;
    hc = 5;
    host.wr(7'h7A, 8'h64);
    host.wr(7'h79, 8'h05);
    wchk(0);
    hs = 255;
    hc = 255;
    host.wr(7'h7A, 8'hFF);
    host.wr(7'h79, 8'hFF);
    wchk(0);
    hc = 3;
    host.wr(7'h79, 8'h03);
    wchk(0);
    $display("test hop done");
    of = -160;
    host.wr(7'h73, 8'h60);
    host.wr(7'h74, 8'h03);
    wchk(0);
    hb = 0;
    host.wr(7'h75, 8'h15);
    wchk(0);
    chk({31'h0, HALF_BAND}, 32'h0);
    hb = 1;
    host.wr(7'h75, 8'h35);
    $display("test offset done");
    @(posedge REF_CLK);
    AFC_EN   <= 1'b1;
    AFC_CORR <= 10'sh050;
    MODE_RX  <= 1'b1;
    wait_for(2);
    of = 80;
    wchk(0);
    @(posedge REF_CLK);
    AFC_EN <= 1'b0;
    of = -160;
    wchk(0);
    hc = 7;
    host.wr(7'h79, 8'h07);
    wait_for(0);
    wait_for(2);
    wchk(0);
    @(posedge REF_CLK);
    MODE_RX <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    $display("test receive done");
    dev = 256;
    host.wr(7'h72, 8'h00);
    host.wr(7'h71, 8'h26);
    @(posedge REF_CLK);
    MODE_TX <= 1'b1;
    TX_DATA <= 1'b1;
    wait_for(1);
    wchk(1);
    @(posedge REF_CLK);
    TX_DATA <= 1'b0;
    wchk(-1);
    @(posedge REF_CLK);
    PKT_BUSY <= 1'b1;
    host.wr(7'h79, 8'h09);
    repeat (12) @(posedge REF_CLK);
    #1;
    chk({31'h0, SETTLING}, 32'h0);
    chk(SYNTH_WORD, exp_word(-1));
    @(posedge REF_CLK);
    PKT_BUSY <= 1'b0;
    hc = 9;
    wait_for(0);
    wait_for(1);
    wchk(-1);
    @(posedge REF_CLK);
    MODE_TX <= 1'b0;
    $display("test transmit done");
    tally_and_finish();
  end
endmodule

/* File: sim/sfc_host_model.sv */
module sfc_host_model (
  input  wire logic       clk,
  output logic            ce,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [6:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ce        = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
  end

  // one write, taken at the edge after the strobe rises
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // read data lands on the taking edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule
